// >>> scp_pkg.sv
// shared constants and types of the servo protection alarm block
package scp_pkg;

  // ----------------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------------
  localparam logic [7:0] SCP_ADDR_CONFIG     = 8'h00;
  localparam logic [7:0] SCP_ADDR_IRQ_STATUS = 8'h04;
  localparam logic [7:0] SCP_ADDR_IRQ_MASK   = 8'h08;
  localparam logic [7:0] SCP_ADDR_ALARM      = 8'h0c;
  localparam logic [7:0] SCP_ADDR_ERROR_CODE = 8'h10;
  localparam logic [7:0] SCP_ADDR_AL_STATUS  = 8'h14;
  localparam logic [7:0] SCP_ADDR_COMMAND    = 8'h18;
  localparam logic [7:0] SCP_ADDR_ESM        = 8'h1c;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int SCP_CFG_SETUP_CHECK   = 0;
  localparam int SCP_CFG_SOFT_LIMIT    = 1;
  localparam int SCP_CFG_FC_ABSOLUTE   = 2;
  localparam int SCP_CFG_LATCH1_ASSIGNED = 3;
  localparam int SCP_CFG_LATCH2_ASSIGNED = 4;
  localparam int SCP_CFG_WIDTH         = 5;
  localparam int SCP_EV_OP_TRANSITION  = 0;
  localparam int SCP_EV_IMPROPER       = 1;
  localparam int SCP_EV_WIDTH          = 2;
  localparam int SCP_CMD_ALARM_CLEAR   = 0;
  // touch probe function word
  localparam int SCP_TP1_ENABLE        = 0;
  localparam int SCP_TP1_SOURCE        = 2;
  localparam int SCP_TP2_ENABLE        = 8;
  localparam int SCP_TP2_SOURCE        = 10;

  // ----------------------------------------------------------------------
  // values
  // ----------------------------------------------------------------------
  localparam logic [SCP_CFG_WIDTH-1:0] SCP_CFG_RESET = 5'h00;
  localparam logic [SCP_EV_WIDTH-1:0]  SCP_EV_RESET  = 2'h0;
  localparam logic [15:0] SCP_CODE_NONE      = 16'h0000;
  localparam logic [7:0]  SCP_CODE_MFR_BASE  = 8'hff;
  localparam logic [7:0]  SCP_ALARM_MAIN_NUM = 8'h88;
  localparam logic [15:0] SCP_AL_STATUS_CODE = 16'h0000;
  localparam logic [2:0]  SCP_POWER_OP_ENABLED = 3'h4;
  localparam logic [2:0]  SCP_POWER_QUICK_STOP = 3'h5;
  localparam logic [1:0]  SCP_SYNC_FREE_RUN  = 2'h0;
  localparam logic [1:0]  SCP_SYNC_SM2       = 2'h1;
  localparam logic [1:0]  SCP_SYNC_DC        = 2'h2;
  localparam logic        SCP_TP_SRC_EXT     = 1'b0;
  localparam logic        SCP_TP_SRC_ZPHASE  = 1'b1;

  typedef enum logic [3:0] {
    SCP_ESM_INIT   = 4'h1,
    SCP_ESM_PREOP  = 4'h2,
    SCP_ESM_SAFEOP = 4'h4,
    SCP_ESM_OP     = 4'h8
  } scp_esm_t;

  // register bus request
  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } scp_bus_req_t;

  // state request from the fieldbus master
  typedef struct packed {
    logic       valid;
    logic [3:0] target;
  } scp_esm_req_t;

  typedef struct packed {
    logic [SCP_CFG_WIDTH-1:0] cfg;
    logic [SCP_EV_WIDTH-1:0]  irq_status;
    logic [SCP_EV_WIDTH-1:0]  irq_mask;
    logic                     alarm_op;
    logic                     alarm_imp;
    scp_esm_t                 esm;
    logic [31:0]              rdata;
    logic                     irq;
    logic [15:0]              err_code;
    logic [15:0]              al_code;
    logic                     err_ind;
  } scp_state_t;

  typedef struct packed {
    logic [1:0] top;
    logic       primed;
    logic       wrap;
  } scp_wrap_state_t;

endpackage

// >>> scp_wrap_det.sv
// position wraparound detector
`timescale 1ns/1ps
module scp_wrap_det #(
  parameter int POS_W = 32
) (
  input  wire logic             mclk,
  input  wire logic             reset_n,
  input  wire logic [POS_W-1:0] position,
  output logic                  wrap
);
  import scp_pkg::*;

  scp_wrap_state_t s_reg;
  scp_wrap_state_t s_next;

  // a wrap is a jump between the two middle quarters of the range (top bits 01 and 10)
  always_comb begin
    s_next        = s_reg;
    s_next.top    = position[POS_W-1 -: 2];
    s_next.primed = 1'b1;
    s_next.wrap   = s_reg.primed &&
                    (((s_reg.top == 2'h1) && (s_next.top == 2'h2)) ||
                     ((s_reg.top == 2'h2) && (s_next.top == 2'h1)));
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  assign wrap = s_reg.wrap;

endmodule

// >>> scp_alarms.sv
// servo fieldbus protection alarms: transition and improper operation
//
// How it works
// RQ1: transition request while powered raises transition alarm
// RQ2: config bit0 adds setup-tool servo-on case
// RQ3: transition check in every state, all sync modes; code checks free-run, SM2 and DC only, not mode 3
// RQ4: device follows master request; master corrects requests
// RQ5: status code register reads zero for both
// RQ6: indicator off; only transition alarm clearable
// RQ7: probe on unassigned external latch raises improper
// RQ8: probe on z-phase in full-closed absolute
// RQ9: soft limit enabled and position wrap
// RQ10: improper check outside init; state kept
// RQ11: error code ff plus main number, ff plus warning code on a warning, else zero
// RQ12: alarm flags latch until allowed clear
`timescale 1ns/1ps
module scp_alarms #(
  parameter int POS_W = 32
) (
  input  wire logic                mclk,
  input  wire logic                reset_n,
  input  wire scp_pkg::scp_bus_req_t bus,
  output logic [31:0]              rdata,
  input  wire scp_pkg::scp_esm_req_t esm_req,
  input  wire logic [2:0]          drive_power_state,
  input  wire logic [1:0]          sync_mode,
  input  wire logic                setup_tool_servo_on_warning,
  input  wire logic                warning_active,
  input  wire logic [7:0]          warning_code,
  input  wire logic [15:0]         touch_probe_func,
  input  wire logic [POS_W-1:0]    actual_position,
  input  wire logic [POS_W-1:0]    command_position,
  output logic [3:0]               esm_state,
  output logic                     operation_time_transition_alarm,
  output logic                     improper_operation_alarm,
  output logic [15:0]              error_code,
  output logic [15:0]              al_status_code,
  output logic                     err_indicator,
  output logic                     irq
);
  import scp_pkg::*;

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic legal_esm(input logic [3:0] s);
    case (s)
      SCP_ESM_INIT, SCP_ESM_PREOP, SCP_ESM_SAFEOP, SCP_ESM_OP:
        legal_esm = 1'b1;
      default: legal_esm = 1'b0;
    endcase
  endfunction

  function automatic logic sync_checked(input logic [1:0] m);
    case (m)
      SCP_SYNC_FREE_RUN, SCP_SYNC_SM2, SCP_SYNC_DC: sync_checked = 1'b1;
      default: sync_checked = 1'b0;
    endcase
  endfunction

  function automatic logic probe_bad(input logic en, input logic src,
                                     input logic assigned,
                                     input logic fc_abs);
    probe_bad = en && (((src == SCP_TP_SRC_EXT) && !assigned) ||
                       ((src == SCP_TP_SRC_ZPHASE) && fc_abs));
  endfunction

  scp_state_t s_reg;
  scp_state_t s_next;
  logic       wrap_act;
  logic       wrap_cmd;
  logic       power_running;
  logic       state_change;
  logic       op_det;
  logic       tp_bad;
  logic       imp_det;
  logic       alarm_clear;

  scp_wrap_det #(.POS_W(POS_W)) u_wrap_act (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .position (actual_position),
    .wrap     (wrap_act)
  );

  scp_wrap_det #(.POS_W(POS_W)) u_wrap_cmd (
    .mclk     (mclk),
    .reset_n  (reset_n),
    .position (command_position),
    .wrap     (wrap_cmd)
  );

  // ----------------------------------------------------------------------
  // detection
  // ----------------------------------------------------------------------
  always_comb begin
    power_running = (drive_power_state == SCP_POWER_OP_ENABLED) ||
                    (drive_power_state == SCP_POWER_QUICK_STOP);
    state_change = esm_req.valid && (esm_req.target != s_reg.esm);
    // RQ1 RQ2 RQ3 powered or setup-tool servo-on
    op_det = state_change && sync_checked(sync_mode) &&
             (power_running ||
              (s_reg.cfg[SCP_CFG_SETUP_CHECK] && setup_tool_servo_on_warning));
    // RQ7 RQ8 probe trigger selection check
    tp_bad = probe_bad(touch_probe_func[SCP_TP1_ENABLE],
                       touch_probe_func[SCP_TP1_SOURCE],
                       s_reg.cfg[SCP_CFG_LATCH1_ASSIGNED],
                       s_reg.cfg[SCP_CFG_FC_ABSOLUTE]) ||
             probe_bad(touch_probe_func[SCP_TP2_ENABLE],
                       touch_probe_func[SCP_TP2_SOURCE],
                       s_reg.cfg[SCP_CFG_LATCH2_ASSIGNED],
                       s_reg.cfg[SCP_CFG_FC_ABSOLUTE]);
    // RQ9 RQ10 wrap check, never in init
    imp_det = (s_reg.esm != SCP_ESM_INIT) && sync_checked(sync_mode) &&
              (tp_bad || (s_reg.cfg[SCP_CFG_SOFT_LIMIT] &&
                          (wrap_act || wrap_cmd)));
    alarm_clear = bus.wr && (bus.addr == SCP_ADDR_COMMAND) &&
                  bus.wdata[SCP_CMD_ALARM_CLEAR];
  end

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_next       = s_reg;
    s_next.rdata = '0;

    // RQ4 RQ10 follow master; alarms never move the state
    if (esm_req.valid && legal_esm(esm_req.target)) begin
      s_next.esm = scp_esm_t'(esm_req.target);
    end

    // RQ12 RQ6 clear only the clearable alarm, set wins
    if (alarm_clear) begin
      s_next.alarm_op = 1'b0;
    end
    if (op_det) begin
      s_next.alarm_op = 1'b1;
    end
    if (imp_det) begin
      s_next.alarm_imp = 1'b1;
    end

    if (bus.wr) begin
      case (bus.addr)
        SCP_ADDR_CONFIG: begin
          s_next.cfg = bus.wdata[SCP_CFG_WIDTH-1:0];
        end
        SCP_ADDR_IRQ_STATUS: begin
          s_next.irq_status = s_reg.irq_status &
                              ~bus.wdata[SCP_EV_WIDTH-1:0];
        end
        SCP_ADDR_IRQ_MASK: begin
          s_next.irq_mask = bus.wdata[SCP_EV_WIDTH-1:0];
        end
        default: begin
        end
      endcase
    end
    // event sets beat a same-cycle write-one-to-clear
    s_next.irq_status[SCP_EV_OP_TRANSITION] =
      s_next.irq_status[SCP_EV_OP_TRANSITION] | op_det;
    s_next.irq_status[SCP_EV_IMPROPER] =
      s_next.irq_status[SCP_EV_IMPROPER] | imp_det;
    s_next.irq = |(s_next.irq_status & s_next.irq_mask);

    // RQ11 alarm outranks a warning
    if (s_next.alarm_op || s_next.alarm_imp) begin
      s_next.err_code = {SCP_CODE_MFR_BASE, SCP_ALARM_MAIN_NUM};
    end else if (warning_active) begin
      s_next.err_code = {SCP_CODE_MFR_BASE, warning_code};
    end else begin
      s_next.err_code = SCP_CODE_NONE;
    end
    // RQ5 RQ6 fixed status code, indicator dark
    s_next.al_code = SCP_AL_STATUS_CODE;
    s_next.err_ind = 1'b0;

    if (bus.rd) begin
      case (bus.addr)
        SCP_ADDR_CONFIG:     s_next.rdata = 32'(s_reg.cfg);
        SCP_ADDR_IRQ_STATUS: s_next.rdata = 32'(s_reg.irq_status);
        SCP_ADDR_IRQ_MASK:   s_next.rdata = 32'(s_reg.irq_mask);
        SCP_ADDR_ALARM:      s_next.rdata = 32'({s_reg.alarm_imp,
                                                 s_reg.alarm_op});
        SCP_ADDR_ERROR_CODE: s_next.rdata = 32'(s_reg.err_code);
        SCP_ADDR_AL_STATUS:  s_next.rdata = 32'(s_reg.al_code);
        SCP_ADDR_ESM:        s_next.rdata = 32'(s_reg.esm);
        default:             s_next.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      s_reg            <= '0;
      s_reg.cfg        <= SCP_CFG_RESET;
      s_reg.irq_status <= SCP_EV_RESET;
      s_reg.irq_mask   <= SCP_EV_RESET;
      s_reg.esm        <= SCP_ESM_INIT;
      s_reg.err_code   <= SCP_CODE_NONE;
      s_reg.al_code    <= SCP_AL_STATUS_CODE;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata                           = s_reg.rdata;
  assign esm_state                       = s_reg.esm;
  assign operation_time_transition_alarm = s_reg.alarm_op;
  assign improper_operation_alarm        = s_reg.alarm_imp;
  assign error_code                      = s_reg.err_code;
  assign al_status_code                  = s_reg.al_code;
  assign err_indicator                   = s_reg.err_ind;
  assign irq                             = s_reg.irq;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  property p_op_powered;
    @(posedge mclk) disable iff (!reset_n)
      (esm_req.valid && (esm_req.target != esm_state) && power_running &&
       sync_checked(sync_mode)) |=> operation_time_transition_alarm;
  endproperty
  a_op_powered: assert property (p_op_powered) // RQ1 RQ3
    else $error("transition alarm missed while powered");

  property p_op_setup;
    @(posedge mclk) disable iff (!reset_n)
      (state_change && s_reg.cfg[SCP_CFG_SETUP_CHECK] &&
       setup_tool_servo_on_warning && sync_checked(sync_mode))
      |=> operation_time_transition_alarm;
  endproperty
  a_op_setup: assert property (p_op_setup) // RQ2
    else $error("transition alarm missed under setup tool");

  property p_op_quiet;
    @(posedge mclk) disable iff (!reset_n)
      (!operation_time_transition_alarm && !power_running &&
       !s_reg.cfg[SCP_CFG_SETUP_CHECK]) |=> !operation_time_transition_alarm;
  endproperty
  a_op_quiet: assert property (p_op_quiet) // RQ2
    else $error("transition alarm without cause");

  property p_follow;
    @(posedge mclk) disable iff (!reset_n)
      (esm_req.valid && legal_esm(esm_req.target))
      |=> (esm_state == $past(esm_req.target));
  endproperty
  a_follow: assert property (p_follow) // RQ4
    else $error("state request not followed");

  property p_fixed_outputs;
    @(posedge mclk) disable iff (!reset_n)
      (al_status_code == SCP_AL_STATUS_CODE) && !err_indicator;
  endproperty
  a_fixed_outputs: assert property (p_fixed_outputs) // RQ5 RQ6
    else $error("status code or indicator not idle");

  property p_imp_sticky;
    @(posedge mclk) disable iff (!reset_n)
      improper_operation_alarm |=> improper_operation_alarm [*2];
  endproperty
  a_imp_sticky: assert property (p_imp_sticky) // RQ6 RQ12
    else $error("improper alarm was cleared");

  property p_tp_check;
    @(posedge mclk) disable iff (!reset_n)
      (tp_bad && (esm_state != SCP_ESM_INIT) && sync_checked(sync_mode))
      |=> improper_operation_alarm;
  endproperty
  a_tp_check: assert property (p_tp_check) // RQ7 RQ8
    else $error("bad probe selection not flagged");

  property p_wrap;
    @(posedge mclk) disable iff (!reset_n)
      ((wrap_act || wrap_cmd) && s_reg.cfg[SCP_CFG_SOFT_LIMIT] &&
       (esm_state != SCP_ESM_INIT) && sync_checked(sync_mode))
      |=> improper_operation_alarm;
  endproperty
  a_wrap: assert property (p_wrap) // RQ9
    else $error("position wrap not flagged");

  property p_init_exempt;
    @(posedge mclk) disable iff (!reset_n)
      (!improper_operation_alarm && (esm_state == SCP_ESM_INIT))
      |=> !improper_operation_alarm;
  endproperty
  a_init_exempt: assert property (p_init_exempt) // RQ10
    else $error("improper alarm raised in init");

  property p_stay;
    @(posedge mclk) disable iff (!reset_n)
      (imp_det && !esm_req.valid) |=> $stable(esm_state);
  endproperty
  a_stay: assert property (p_stay) // RQ10
    else $error("state moved on improper alarm");

  property p_code;
    @(posedge mclk) disable iff (!reset_n)
      (operation_time_transition_alarm || improper_operation_alarm)
      |-> (error_code == {SCP_CODE_MFR_BASE, SCP_ALARM_MAIN_NUM});
  endproperty
  a_code: assert property (p_code) // RQ11
    else $error("error code does not show the alarm");

  property p_code_none;
    @(posedge mclk) disable iff (!reset_n)
      (!operation_time_transition_alarm && !improper_operation_alarm &&
       !warning_active && !op_det && !imp_det) |=>
      (error_code == SCP_CODE_NONE);
  endproperty
  a_code_none: assert property (p_code_none) // RQ11
    else $error("error code not zero when idle");

  property p_clear;
    @(posedge mclk) disable iff (!reset_n)
      (alarm_clear && !op_det) |=> !operation_time_transition_alarm;
  endproperty
  a_clear: assert property (p_clear) // RQ12
    else $error("transition alarm not cleared");

  c_op_alarm: cover property (@(posedge mclk) disable iff (!reset_n)
    $rose(operation_time_transition_alarm));
  c_imp_alarm: cover property (@(posedge mclk) disable iff (!reset_n)
    $rose(improper_operation_alarm));
  c_cleared: cover property (@(posedge mclk) disable iff (!reset_n)
    $fell(operation_time_transition_alarm));
  c_irq: cover property (@(posedge mclk) disable iff (!reset_n)
    $rose(irq));

endmodule

// >>> scp_master_model.sv
// fieldbus master model that issues state requests
`timescale 1ns/1ps
module scp_master_model
  import scp_pkg::*;
(
  input  wire logic             mclk,
  output scp_pkg::scp_esm_req_t esm_req
);
  initial esm_req = '0;

  // ----------------------------------------------------------------------
  // request driver
  // ----------------------------------------------------------------------
  // master sends only one-hot targets
  task automatic send(input logic [3:0] target);
    @(posedge mclk);
    esm_req <= '{valid: 1'b1, target: target};
    @(posedge mclk);
    // stale target must not look like a request
    esm_req <= '{valid: 1'b0, target: ~target};
  endtask
endmodule

// >>> testbench.sv
// self-checking bench of the servo protection alarm block
`timescale 1ns/1ps
module testbench;
  import scp_pkg::*;
  logic                  mclk = 1'b0;
  logic                  reset_n = 1'b0;
  scp_bus_req_t          bus = '0;
  logic [31:0]           rdata;
  scp_esm_req_t          esm_req;
  logic [2:0]            power_state = 3'h0;
  logic [1:0]            sync_mode = 2'h0;
  logic                  setup_warn = 1'b0;
  logic                  warn_act = 1'b0;
  logic [7:0]            warn_code = 8'h00;
  logic [15:0]           tp_func = 16'h0000;
  logic [31:0]           act_pos = 32'h0;
  logic [31:0]           cmd_pos = 32'h0;
  logic [3:0]            esm_state;
  logic                  op_alarm;
  logic                  imp_alarm;
  logic [15:0]           error_code;
  logic [15:0]           al_code;
  logic                  err_ind;
  logic                  irq;
  logic [31:0]           rd_val;
  int                    err_total = 0;
  int                    check_count = 0;
  int                    cyc_count = 0;

  scp_alarms #(.POS_W(32)) i_scp_alarms (
    .mclk                            (mclk),
    .reset_n                         (reset_n),
    .bus                             (bus),
    .rdata                           (rdata),
    .esm_req                         (esm_req),
    .drive_power_state               (power_state),
    .sync_mode                       (sync_mode),
    .setup_tool_servo_on_warning     (setup_warn),
    .warning_active                  (warn_act),
    .warning_code                    (warn_code),
    .touch_probe_func                (tp_func),
    .actual_position                 (act_pos),
    .command_position                (cmd_pos),
    .esm_state                       (esm_state),
    .operation_time_transition_alarm (op_alarm),
    .improper_operation_alarm        (imp_alarm),
    .error_code                      (error_code),
    .al_status_code                  (al_code),
    .err_indicator                   (err_ind),
    .irq                             (irq)
  );

  scp_master_model i_scp_master_model (
    .mclk    (mclk),
    .esm_req (esm_req)
  );

  initial begin
    forever #2 mclk = ~mclk;
  end

  // ----------------------------------------------------------------------
  // common tasks
  // ----------------------------------------------------------------------
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // hang guard: whole run needs well under 3000 cycles
  always @(posedge mclk) begin
    cyc_count++;
    if (cyc_count == 3000) begin
      err_total++;
      tally_and_finish();
    end
  end

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task automatic do_reset;
    @(posedge mclk);
    reset_n <= 1'b0;
    power_state <= 3'h0;
    sync_mode <= 2'h0;
    setup_warn <= 1'b0;
    warn_act <= 1'b0;
    tp_func <= 16'h0000;
    act_pos <= 32'h0;
    cmd_pos <= 32'h0;
    repeat (20) @(posedge mclk);
    reset_n <= 1'b1;
  endtask

  task automatic bus_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
  endtask

  task automatic bus_rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    #1;
    d = rdata;
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    bus_rd(a, rd_val);
    chk(rd_val, e);
  endtask

  task automatic req(input logic [3:0] t);
    i_scp_master_model.send(t);
    #1;
  endtask

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  task automatic t_reset_regs;
    do_reset();
    cyc(1);
    chk(esm_state, 32'h1);
    chk({op_alarm, imp_alarm, err_ind, irq}, 32'h0);
    chk(error_code, 32'h0);
    rd_chk(SCP_ADDR_CONFIG, 32'h0);
    rd_chk(SCP_ADDR_ESM, 32'h1);
    rd_chk(8'h20, 32'h0);
    bus_wr(SCP_ADDR_AL_STATUS, 32'hffff);
    rd_chk(SCP_ADDR_AL_STATUS, 32'h0);
    bus_wr(SCP_ADDR_CONFIG, 32'h1f);
    rd_chk(SCP_ADDR_CONFIG, 32'h1f);
    rd_chk(SCP_ADDR_COMMAND, 32'h0);
    $display("test reset_regs done");
  endtask

  task automatic t_op_transition;
    logic [3:0] tg [6] = '{4'h2, 4'h4, 4'h8, 4'h1, 4'h2, 4'h4};
    do_reset();
    for (int i = 0; i < 6; i++) begin
      @(posedge mclk);
      power_state <= (i < 3) ? SCP_POWER_OP_ENABLED : SCP_POWER_QUICK_STOP;
      sync_mode <= 2'(i % 3);
      req(tg[i]);
      chk(op_alarm, 32'h1);
      chk(esm_state, tg[i]);
      chk(error_code, 32'hff88);
      chk({al_code, 15'h0, err_ind}, 32'h0);
      bus_wr(SCP_ADDR_COMMAND, 32'h1);
      #1;
      chk(op_alarm, 32'h0);
    end
    // request of the present state is no transition
    req(4'h4);
    chk(op_alarm, 32'h0);
    @(posedge mclk);
    power_state <= 3'h0;
    req(4'h8);
    chk({op_alarm, esm_state}, 32'h08);
    // unsupported sync mode: no detection
    @(posedge mclk);
    power_state <= SCP_POWER_OP_ENABLED;
    sync_mode <= 2'h3;
    req(4'h1);
    chk({op_alarm, esm_state}, 32'h01);
    $display("test op_transition done");
  endtask

  task automatic t_setup_tool;
    do_reset();
    @(posedge mclk);
    setup_warn <= 1'b1;
    req(4'h2);
    chk(op_alarm, 32'h0);
    bus_wr(SCP_ADDR_CONFIG, 32'h1);
    req(4'h4);
    chk(op_alarm, 32'h1);
    $display("test setup_tool done");
  endtask

  task automatic t_irq;
    do_reset();
    bus_wr(SCP_ADDR_IRQ_MASK, 32'h1);
    @(posedge mclk);
    power_state <= SCP_POWER_OP_ENABLED;
    req(4'h2);
    chk(irq, 32'h1);
    rd_chk(SCP_ADDR_IRQ_STATUS, 32'h1);
    rd_chk(SCP_ADDR_ALARM, 32'h1);
    rd_chk(SCP_ADDR_ERROR_CODE, 32'hff88);
    bus_wr(SCP_ADDR_COMMAND, 32'h1);
    bus_wr(SCP_ADDR_IRQ_STATUS, 32'h1);
    #1;
    chk(irq, 32'h0);
    rd_chk(SCP_ADDR_IRQ_STATUS, 32'h0);
    bus_wr(SCP_ADDR_IRQ_MASK, 32'h0);
    req(4'h4);
    chk(irq, 32'h0);
    rd_chk(SCP_ADDR_IRQ_STATUS, 32'h1);
    rd_chk(SCP_ADDR_ESM, 32'h4);
    $display("test irq done");
  endtask

  task automatic t_probe(input logic [4:0] cfg, input logic [15:0] tp,
                         input logic exp);
    do_reset();
    bus_wr(SCP_ADDR_CONFIG, {27'h0, cfg});
    @(posedge mclk);
    tp_func <= tp;
    cyc(3);
    chk(imp_alarm, 32'h0);
    req(4'h2);
    cyc(3);
    chk({imp_alarm, esm_state}, {27'h0, exp, 4'h2});
    bus_wr(SCP_ADDR_COMMAND, 32'h1);
    cyc(2);
    chk({imp_alarm, err_ind, al_code}, {14'h0, exp, 17'h0});
    $display("test probe done");
  endtask

  task automatic t_wrap(input logic [4:0] cfg, input logic use_cmd,
                        input logic exp);
    do_reset();
    bus_wr(SCP_ADDR_CONFIG, {27'h0, cfg});
    req(4'h2);
    @(posedge mclk);
    if (use_cmd) cmd_pos <= 32'h8000_0000;
    else act_pos <= 32'h7fff_ffff;
    cyc(4);
    chk(imp_alarm, 32'h0);
    @(posedge mclk);
    if (use_cmd) cmd_pos <= 32'h7fff_ffff;
    else act_pos <= 32'h8000_0000;
    cyc(4);
    chk(imp_alarm, exp);
    $display("test wrap done");
  endtask

  task automatic t_warn_code;
    do_reset();
    @(posedge mclk);
    warn_act <= 1'b1;
    warn_code <= 8'h12;
    cyc(3);
    chk(error_code, 32'hff12);
    @(posedge mclk);
    power_state <= SCP_POWER_OP_ENABLED;
    req(4'h2);
    chk(error_code, 32'hff88);
    bus_wr(SCP_ADDR_COMMAND, 32'h1);
    @(posedge mclk);
    warn_act <= 1'b0;
    cyc(3);
    chk(error_code, 32'h0);
    $display("test warn_code done");
  endtask

  initial begin
    t_reset_regs();
    t_op_transition();
    t_setup_tool();
    t_irq();
    t_probe(5'h00, 16'h0001, 1'b1);
    t_probe(5'h08, 16'h0101, 1'b1);
    t_probe(5'h0c, 16'h0005, 1'b1);
    t_probe(5'h18, 16'h0101, 1'b0);
    t_probe(5'h08, 16'h0005, 1'b0);
    t_wrap(5'h02, 1'b0, 1'b1);
    t_wrap(5'h02, 1'b1, 1'b1);
    t_wrap(5'h00, 1'b0, 1'b0);
    t_warn_code();
    tally_and_finish();
  end
endmodule
